// [pkg/host_cmd_consts.vh]
// Functional notes
// - every error reply byte carries hex E in its upper nibble
// - status register read with index above five replies invalid-register error
// - unknown opcode byte replies invalid-command error
// - fabric clear with bad output code changes nothing, replies invalid-clear error
// - fabric set with bad output code drives nothing, replies invalid-set error
// - fabric read with bad input code replies invalid-read error
// - bad shared-memory location gives byte, halfword or word specific error
// - forwarded command starts two-second timer; expiry replies processor-timeout error
// - codes 0x01-0x07 except 0x04 read the direct analog inputs as logic
// - codes 0x16-0x19, 0x20, 0x22, 0x24, 0x68 are outputs; 0x21, 0x23 inputs
// - processor I/O code hex digits read as decimal GPIO bit, up to 0x31
// - GPIO bit 24 lamp is active low, driven high is dark
// - processor pin commands accept only bits sixteen through thirty-one
// - pin read replies 0x00 for low and 0x01 for high
`ifndef HOST_CMD_CONSTS_VH
`define HOST_CMD_CONSTS_VH

// opcodes
`define OP_REG_READ 8'h10
`define OP_LOOPBACK 8'h20
`define OP_LOOP_INV 8'h21
`define OP_FAB_READ 8'h30
`define OP_FAB_CLEAR 8'h40
`define OP_FAB_SET 8'h41
`define OP_SHM_WRITE_HI 4'h5
`define OP_SHM_READ_HI 4'h6
`define OP_PING 8'h70
`define OP_PS_STATUS_HI 4'h8
`define OP_PS_STATUS_LAST 4'ha
`define OP_GPIO_READ 8'h90
`define OP_GPIO_CLEAR 8'ha0
`define OP_GPIO_SET 8'ha1
`define OP_MEM_TEST 8'hb0
`define OP_DAC_HI 4'hc
`define OP_DAC_LAST 4'h3
`define OP_DAC0_LOAD 8'hc0
`define OP_DAC1_LOAD 8'hc1
`define OP_ADC_HI 4'hd
`define OP_ADC_MV 8'hd0
`define OP_ADC_RAW_TM 8'hd9
`define OP_ADC_RAW_D0 8'hda
`define OP_ADC_RAW_D1 8'hdb

// error replies
`define ERR_NIBBLE 4'he
`define ERR_INV_REG 8'he0
`define ERR_INV_CMD 8'he1
`define ERR_INV_CLEAR 8'he2
`define ERR_INV_SET 8'he3
`define ERR_INV_READ 8'he4
`define ERR_SHM_BYTE 8'he5
`define ERR_PS_TIMEOUT 8'he8
`define ERR_PS_INV_CMD 8'he9

// replies and limits
`define PIN_LOW_REPLY 8'h00
`define PIN_HIGH_REPLY 8'h01
`define REG_IDX_MAX 8'h05
`define BCD_DIGIT_MAX 4'h9
`define GPIO_MIN_BIT 8'h10
`define GPIO_MAX_BIT 8'h1f
`define GPIO_RESET 32'hffff_ffff
`define FAB_OUT_RESET 8'h00
`define LAMP_GPIO_BIT 24
`define SHM_LAST_BYTE 8'h07
`define SHM_LAST_HALF 8'h06
`define SHM_LAST_WORD 8'h04
`define SZ_BYTE 2'h0
`define SZ_HALF 2'h1
`define SZ_WORD 2'h2
`define ADC_REPLY_BYTES 2'h2
`define ONE_REPLY_BYTE 2'h1

// fabric pin codes
`define FIN_A1 8'h01
`define FIN_A2 8'h02
`define FIN_A3 8'h03
`define FIN_A5 8'h05
`define FIN_A6 8'h06
`define FIN_A7 8'h07
`define FIN_21 8'h21
`define FIN_23 8'h23
`define FOUT_16 8'h16
`define FOUT_17 8'h17
`define FOUT_18 8'h18
`define FOUT_19 8'h19
`define FOUT_20 8'h20
`define FOUT_22 8'h22
`define FOUT_24 8'h24
`define FOUT_68 8'h68

// timing
`define CLK_HZ 50000000
`define MS_PER_S 1000
`define PS_TIMEOUT_MS 2000

`endif

// [rtl/pin_sync2.v]
`timescale 1ns/100ps
`default_nettype none
module pin_sync2 #(
   parameter WIDTH = 1
) (
   input wire i_clk, // system clock
   input wire i_rst_n, // async reset, active low
   input wire [WIDTH-1:0] i_async, // pins from outside the clock domain
   output reg [WIDTH-1:0] o_sync // synchronised copy
);
   reg [WIDTH-1:0] stage1;

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stage1 <= {WIDTH{1'b0}};
         o_sync <= {WIDTH{1'b0}};
      end else begin
         stage1 <= i_async;
         o_sync <= stage1;
      end
   end
endmodule // pin_sync2
`default_nettype wire

// [rtl/ps_timeout_timer.v]
`timescale 1ns/100ps
`default_nettype none
module ps_timeout_timer #(
   parameter TICK_CYCLES = 50000,
   parameter TIMEOUT_TICKS = 2000
) (
   input wire i_clk, // system clock
   input wire i_rst_n, // async reset, active low
   input wire i_run, // high while a processor answer is awaited
   output reg o_expired // level, high once the limit is reached until run drops
);
   reg [31:0] div_cnt;
   reg [31:0] tick_cnt;
   wire tick;

   // millisecond enable, so the long count counts milliseconds, held in a 32-bit register
   assign tick = (div_cnt == TICK_CYCLES - 1);

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         div_cnt <= 32'h0;
         tick_cnt <= 32'h0;
         o_expired <= 1'b0;
      end else if (!i_run) begin
         div_cnt <= 32'h0;
         tick_cnt <= 32'h0;
         o_expired <= 1'b0;
      end else begin
         div_cnt <= tick ? 32'h0 : div_cnt + 32'h1;
         if (tick && !o_expired) begin
            tick_cnt <= tick_cnt + 32'h1;
            if (tick_cnt == TIMEOUT_TICKS - 1)
               o_expired <= 1'b1;
         end
      end
   end
endmodule // ps_timeout_timer
`default_nettype wire

// [rtl/host_command_error_checker.v]
`timescale 1ns/100ps
`default_nettype none
`include "host_cmd_consts.vh"
module host_command_error_checker #(
   parameter TICK_CYCLES = `CLK_HZ / `MS_PER_S,
   parameter TIMEOUT_TICKS = `PS_TIMEOUT_MS
) (
   input wire i_clk, // system clock, 50 MHz
   input wire i_rst_n, // async reset, active low
   input wire i_rx_valid, // host byte available
   input wire [7:0] i_rx_data, // host byte
   output wire o_rx_ready, // host byte taken when high with valid
   output wire o_tx_valid, // reply byte available
   output reg [7:0] o_tx_data, // reply byte
   input wire i_tx_ready, // reply byte taken
   output reg o_ps_valid, // byte offered to processor
   output reg [7:0] o_ps_data, // byte to processor
   input wire i_ps_ready, // processor took the byte
   input wire i_ps_resp_valid, // processor answer byte available
   input wire [7:0] i_ps_resp_data, // processor answer byte
   output wire o_ps_resp_ready, // answer byte taken
   input wire i_shm_req, // processor shared-memory access pulse
   input wire [1:0] i_shm_size, // 0 byte, 1 halfword, 2 word
   input wire [7:0] i_shm_addr, // shared-memory location
   input wire [47:0] i_status_regs, // status registers 0..5, byte 0 lowest
   input wire [5:0] i_analog_in, // direct analog inputs, codes 1,2,3,5,6,7
   input wire i_fabric_input_pin_21, // fabric digital input, code 0x21
   input wire i_fabric_input_pin_23, // fabric digital input, code 0x23
   output wire [6:0] o_fab_out, // outputs for codes 16,17,18,19,20,22,24
   output wire o_fabric_output_pin_68, // fabric digital output, code 0x68
   input wire [31:0] i_gpio_in, // processor GPIO pin levels
   output reg [31:0] o_gpio_out, // processor GPIO drive levels
   output wire o_status_lamp_gpio // lamp drive, low lights it
);
   localparam S_IDLE = 3'h0;
   localparam S_PARAM = 3'h1;
   localparam S_FWD = 3'h2;
   localparam S_WAIT = 3'h3;
   localparam S_SEND = 3'h4;

   localparam CL_BAD = 2'h0;
   localparam CL_LOCAL = 2'h1;
   localparam CL_FWD = 2'h2;

   reg [2:0] state;
   reg [2:0] ret_state;
   reg [7:0] op;
   reg [7:0] fab_out;
   reg fwd_left;
   reg [1:0] resp_left;
   reg ps_busy;
   reg shm_pend;
   reg [7:0] shm_code;
   wire [39:0] pins_sync;
   wire [7:0] fin_sync;
   wire [31:0] gpio_sync;
   wire expired;
   wire shm_take;
   wire [3:0] fin;
   wire [3:0] fout;
   wire [5:0] gsel;

   ////////////////////////////////////////////////////////////////////////
   // decoding helpers

   function [1:0] op_class;
      input [7:0] c;
      begin
         if (c == `OP_REG_READ || c == `OP_FAB_READ || c == `OP_FAB_CLEAR ||
             c == `OP_FAB_SET || c == `OP_GPIO_READ || c == `OP_GPIO_CLEAR ||
             c == `OP_GPIO_SET)
            op_class = CL_LOCAL;
         else if (c == `OP_LOOPBACK || c == `OP_LOOP_INV || c == `OP_PING ||
                  c == `OP_MEM_TEST || c == `OP_ADC_MV || c == `OP_ADC_RAW_TM ||
                  c == `OP_ADC_RAW_D0 || c == `OP_ADC_RAW_D1 ||
                  ((c[7:4] == `OP_SHM_WRITE_HI || c[7:4] == `OP_SHM_READ_HI) && !c[3]) ||
                  (c[7:4] == `OP_PS_STATUS_HI && c[3:0] <= `OP_PS_STATUS_LAST) ||
                  (c[7:4] == `OP_DAC_HI && c[3:0] <= `OP_DAC_LAST))
            op_class = CL_FWD;
         else
            op_class = CL_BAD;
      end
   endfunction

   // forwarded commands that carry one parameter byte
   function fwd_param;
      input [7:0] c;
      begin
         fwd_param = (c == `OP_LOOPBACK) || (c == `OP_LOOP_INV) ||
                     (c[7:4] == `OP_SHM_WRITE_HI) ||
                     (c == `OP_DAC0_LOAD) || (c == `OP_DAC1_LOAD);
      end
   endfunction

   // {valid, index} into the synchronised fabric inputs
   function [3:0] fab_in_sel;
      input [7:0] c;
      begin
         case (c)
            `FIN_A1: fab_in_sel = 4'h8;
            `FIN_A2: fab_in_sel = 4'h9;
            `FIN_A3: fab_in_sel = 4'ha;
            `FIN_A5: fab_in_sel = 4'hb;
            `FIN_A6: fab_in_sel = 4'hc;
            `FIN_A7: fab_in_sel = 4'hd;
            `FIN_21: fab_in_sel = 4'he;
            `FIN_23: fab_in_sel = 4'hf;
            default: fab_in_sel = 4'h0;
         endcase
      end
   endfunction

   // {valid, index} into the fabric output register
   function [3:0] fab_out_sel;
      input [7:0] c;
      begin
         case (c)
            `FOUT_16: fab_out_sel = 4'h8;
            `FOUT_17: fab_out_sel = 4'h9;
            `FOUT_18: fab_out_sel = 4'ha;
            `FOUT_19: fab_out_sel = 4'hb;
            `FOUT_20: fab_out_sel = 4'hc;
            `FOUT_22: fab_out_sel = 4'hd;
            `FOUT_24: fab_out_sel = 4'he;
            `FOUT_68: fab_out_sel = 4'hf;
            default: fab_out_sel = 4'h0;
         endcase
      end
   endfunction

   // hex digits read as a decimal bit number: {valid, bit}
   function [5:0] gpio_sel;
      input [7:0] c;
      reg [7:0] dec;
      begin
         dec = {1'b0, c[7:4], 3'h0} + {3'h0, c[7:4], 1'b0} + {4'h0, c[3:0]};
         gpio_sel = {(c[3:0] <= `BCD_DIGIT_MAX) && (dec >= `GPIO_MIN_BIT) &&
                     (dec <= `GPIO_MAX_BIT), dec[4:0]};
      end
   endfunction

   // an access that runs past location 7 or is misaligned is invalid
   function shm_bad;
      input [1:0] sz;
      input [7:0] a;
      begin
         if (sz == `SZ_BYTE)
            shm_bad = (a > `SHM_LAST_BYTE);
         else if (sz == `SZ_HALF)
            shm_bad = a[0] || (a > `SHM_LAST_HALF);
         else if (sz == `SZ_WORD)
            shm_bad = (a[1:0] != 2'h0) || (a > `SHM_LAST_WORD);
         else
            shm_bad = 1'b1;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers and timer

   pin_sync2 #(
      .WIDTH(40)
   ) u_sync (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_async({i_gpio_in, i_fabric_input_pin_23, i_fabric_input_pin_21, i_analog_in}),
      .o_sync(pins_sync)
   );
   assign fin_sync = pins_sync[7:0];
   assign gpio_sync = pins_sync[39:8];

   ps_timeout_timer #(
      .TICK_CYCLES(TICK_CYCLES),
      .TIMEOUT_TICKS(TIMEOUT_TICKS)
   ) u_timer (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_run(ps_busy),
      .o_expired(expired)
   );

   ////////////////////////////////////////////////////////////////////////
   // handshakes

   assign shm_take = (state == S_IDLE) && shm_pend;
   assign o_rx_ready = ((state == S_IDLE) && !shm_pend) || (state == S_PARAM) ||
                       ((state == S_FWD) && !o_ps_valid && fwd_left);
   assign o_tx_valid = (state == S_SEND);
   assign o_ps_resp_ready = (state == S_WAIT);
   assign o_fab_out = fab_out[6:0];
   assign o_fabric_output_pin_68 = fab_out[7];
   assign o_status_lamp_gpio = o_gpio_out[`LAMP_GPIO_BIT];
   assign fin = fab_in_sel(i_rx_data);
   assign fout = fab_out_sel(i_rx_data);
   assign gsel = gpio_sel(i_rx_data);

   // a new bad access in the cycle the old one is taken still gets reported
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         shm_pend <= 1'b0;
         shm_code <= `ERR_SHM_BYTE;
      end else if (i_shm_req && shm_bad(i_shm_size, i_shm_addr)) begin
         shm_pend <= 1'b1;
         shm_code <= `ERR_SHM_BYTE + {6'h0, i_shm_size};
      end else if (shm_take) begin
         shm_pend <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // command sequencer

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= S_IDLE;
         ret_state <= S_IDLE;
         op <= 8'h00;
         o_tx_data <= 8'h00;
         o_ps_valid <= 1'b0;
         o_ps_data <= 8'h00;
         fwd_left <= 1'b0;
         resp_left <= 2'h0;
         ps_busy <= 1'b0;
         fab_out <= `FAB_OUT_RESET;
         o_gpio_out <= `GPIO_RESET;
      end else begin
         case (state)
            S_IDLE: begin
               ret_state <= S_IDLE;
               if (shm_pend) begin
                  o_tx_data <= shm_code;
                  state <= S_SEND;
               end else if (i_rx_valid) begin
                  op <= i_rx_data;
                  if (op_class(i_rx_data) == CL_LOCAL) begin
                     state <= S_PARAM;
                  end else if (op_class(i_rx_data) == CL_FWD) begin
                     o_ps_data <= i_rx_data;
                     o_ps_valid <= 1'b1;
                     fwd_left <= fwd_param(i_rx_data);
                     resp_left <= (i_rx_data[7:4] == `OP_ADC_HI) ?
                                  `ADC_REPLY_BYTES : `ONE_REPLY_BYTE;
                     state <= S_FWD;
                  end else begin
                     o_tx_data <= `ERR_INV_CMD;
                     state <= S_SEND;
                  end
               end
            end
            S_PARAM: begin
               if (i_rx_valid) begin
                  state <= S_SEND;
                  o_tx_data <= i_rx_data;
                  if (op == `OP_REG_READ) begin
                     if (i_rx_data > `REG_IDX_MAX)
                        o_tx_data <= `ERR_INV_REG;
                     else
                        o_tx_data <= i_status_regs[i_rx_data[2:0]*8 +: 8];
                  end else if (op == `OP_FAB_READ) begin
                     if (!fin[3])
                        o_tx_data <= `ERR_INV_READ;
                     else
                        o_tx_data <= fin_sync[fin[2:0]] ?
                                     `PIN_HIGH_REPLY : `PIN_LOW_REPLY;
                  end else if (op == `OP_FAB_CLEAR) begin
                     if (!fout[3])
                        o_tx_data <= `ERR_INV_CLEAR;
                     else
                        fab_out[fout[2:0]] <= 1'b0;
                  end else if (op == `OP_FAB_SET) begin
                     if (!fout[3])
                        o_tx_data <= `ERR_INV_SET;
                     else
                        fab_out[fout[2:0]] <= 1'b1;
                  end else if (op == `OP_GPIO_READ) begin
                     if (!gsel[5])
                        o_tx_data <= `ERR_INV_READ;
                     else
                        o_tx_data <= gpio_sync[gsel[4:0]] ?
                                     `PIN_HIGH_REPLY : `PIN_LOW_REPLY;
                  end else if (op == `OP_GPIO_CLEAR) begin
                     if (!gsel[5])
                        o_tx_data <= `ERR_INV_CLEAR;
                     else
                        o_gpio_out[gsel[4:0]] <= 1'b0;
                  end else begin
                     if (!gsel[5])
                        o_tx_data <= `ERR_INV_SET;
                     else
                        o_gpio_out[gsel[4:0]] <= 1'b1;
                  end
               end
            end
            S_FWD: begin
               if (o_ps_valid && i_ps_ready) begin
                  o_ps_valid <= 1'b0;
                  if (!fwd_left) begin
                     ps_busy <= 1'b1;
                     state <= S_WAIT;
                  end
               end else if (!o_ps_valid && i_rx_valid) begin
                  o_ps_data <= i_rx_data;
                  o_ps_valid <= 1'b1;
                  fwd_left <= 1'b0;
               end
            end
            S_WAIT: begin
               // an answer in the expiry cycle still counts as in time
               if (i_ps_resp_valid) begin
                  o_tx_data <= i_ps_resp_data;
                  resp_left <= resp_left - 2'h1;
                  state <= S_SEND;
                  if (resp_left == `ONE_REPLY_BYTE ||
                      i_ps_resp_data[7:4] == `ERR_NIBBLE) begin
                     ps_busy <= 1'b0;
                     ret_state <= S_IDLE;
                  end else begin
                     ret_state <= S_WAIT;
                  end
               end else if (expired) begin
                  o_tx_data <= `ERR_PS_TIMEOUT;
                  ps_busy <= 1'b0;
                  ret_state <= S_IDLE;
                  state <= S_SEND;
               end
            end
            S_SEND: begin
               if (i_tx_ready)
                  state <= ret_state;
            end
            default: state <= S_IDLE;
         endcase
      end
   end
endmodule // host_command_error_checker
`default_nettype wire

// [sim/ps_responder.sv]
`timescale 1ns/100ps
`default_nettype none
module ps_responder (
   input wire logic i_clk, // system clock
   input wire logic i_rst_n, // async reset, active low
   input wire logic i_valid, // byte offered by the fabric
   input wire logic [7:0] i_data, // byte from the fabric
   output logic o_ready, // byte taken
   output logic o_resp_valid, // answer byte present
   output logic [7:0] o_resp_data, // answer byte
   input wire logic i_resp_ready, // answer taken
   input wire logic i_mute, // never answer, to force a timeout
   input wire logic [3:0] i_delay // cycles before answering
);
   int cnt;
   logic [7:0] ans;
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_ready <= 1'b0;
         o_resp_valid <= 1'b0;
         o_resp_data <= 8'h00;
         ans <= 8'h00;
         cnt <= -1;
      end else begin
         // registered ready, so the fabric must hold its offer a cycle
         o_ready <= i_valid && !o_ready;
         if (i_valid && o_ready) begin
            ans <= (i_data == 8'h70) ? 8'hc3 : 8'he9;
            cnt <= i_mute ? -1 : int'(i_delay);
         end else if (cnt > 0) begin
            cnt <= cnt - 1;
         end else if (cnt == 0) begin
            o_resp_valid <= 1'b1;
            o_resp_data <= ans;
            cnt <= -1;
         end
         // released data line shows the inverse, not a stale copy
         if (o_resp_valid && i_resp_ready) begin
            o_resp_valid <= 1'b0;
            o_resp_data <= ~o_resp_data;
         end
      end
   end
endmodule // ps_responder
`default_nettype wire

// [sim/host_command_error_checker_checker.sv]
`timescale 1ns/100ps
`default_nettype none
module error_reply_checker #(
   parameter TICK_CYCLES = 4,
   parameter TIMEOUT_TICKS = 3
) (
   input wire logic i_clk, // system clock
   input wire logic i_rst_n, // async reset, active low
   input wire logic o_rx_ready, // host byte accepted
   input wire logic o_tx_valid, // reply present
   input wire logic [7:0] o_tx_data, // reply byte
   input wire logic i_tx_ready, // reply taken
   input wire logic o_ps_valid, // byte to processor
   input wire logic [7:0] o_ps_data, // processor byte
   input wire logic i_ps_ready, // processor took byte
   input wire logic i_ps_resp_valid, // answer present
   input wire logic [7:0] i_ps_resp_data, // answer byte
   input wire logic o_ps_resp_ready, // waiting for answer
   input wire logic i_shm_req, // shared-memory access
   input wire logic [1:0] i_shm_size, // access width
   input wire logic [7:0] i_shm_addr, // access location
   input wire logic [31:0] o_gpio_out, // gpio drive
   input wire logic o_status_lamp_gpio // lamp drive
);
   int wait_cnt;
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wait_cnt <= 0;
      end else begin
         wait_cnt <= o_ps_resp_ready ? wait_cnt + 1 : 0;
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   a_reply_hold: assert property (
      o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
      else $error("reply byte changed before taken");
   a_ps_offer_hold: assert property (
      o_ps_valid && !i_ps_ready |=> o_ps_valid && $stable(o_ps_data))
      else $error("processor byte changed before taken");
   a_rx_blocked_send: assert property (o_tx_valid |-> !o_rx_ready)
      else $error("host byte accepted while a reply is pending");
   // the lamp may only move on a set or clear of code 0x24, echoed at once
   a_lamp_code_only: assert property (
      $changed(o_status_lamp_gpio) |-> o_tx_valid && o_tx_data == 8'h24)
      else $error("lamp moved without a code 0x24 command");
   a_shm_byte_err: assert property (
      i_shm_req && i_shm_size == 2'h0 && i_shm_addr > 8'h07
      |-> ##[1:40] o_tx_valid && o_tx_data == 8'he5) else $error("no byte access error");
   a_shm_half_err: assert property (
      i_shm_req && i_shm_size == 2'h1 && i_shm_addr[0]
      |-> ##[1:40] o_tx_valid && o_tx_data == 8'he6) else $error("no halfword access error");
   a_shm_word_err: assert property (
      i_shm_req && i_shm_size == 2'h2 && i_shm_addr[1:0] != 2'h0
      |-> ##[1:40] o_tx_valid && o_tx_data == 8'he7) else $error("no word access error");
   a_ps_err_relay: assert property (
      i_ps_resp_valid && o_ps_resp_ready && i_ps_resp_data[7:4] == 4'he
      |=> o_tx_valid && o_tx_data == $past(i_ps_resp_data)) else $error("answer not relayed");
   a_timeout_code: assert property (
      $fell(o_ps_resp_ready) && !$past(i_ps_resp_valid) |-> o_tx_valid && o_tx_data == 8'he8)
      else $error("wait ended without answer or timeout code");
   a_timeout_bound: assert property (wait_cnt <= TICK_CYCLES * TIMEOUT_TICKS + 4)
      else $error("processor wait outlived the timeout");
endmodule // error_reply_checker
bind host_command_error_checker error_reply_checker #(.TICK_CYCLES(TICK_CYCLES),
   .TIMEOUT_TICKS(TIMEOUT_TICKS)) chk_u (.i_clk(i_clk), .i_rst_n(i_rst_n),
   .o_rx_ready(o_rx_ready), .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data),
   .i_tx_ready(i_tx_ready), .o_ps_valid(o_ps_valid), .o_ps_data(o_ps_data),
   .i_ps_ready(i_ps_ready), .i_ps_resp_valid(i_ps_resp_valid),
   .i_ps_resp_data(i_ps_resp_data), .o_ps_resp_ready(o_ps_resp_ready),
   .i_shm_req(i_shm_req), .i_shm_size(i_shm_size), .i_shm_addr(i_shm_addr),
   .o_gpio_out(o_gpio_out), .o_status_lamp_gpio(o_status_lamp_gpio));
`default_nettype wire

// [sim/host_command_error_checker_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module host_command_error_checker_tb;
   logic i_clk = 1'b0;
   logic i_rst_n, rx_valid, rx_ready, tx_valid, tx_ready, ps_valid, ps_ready;
   logic resp_valid, resp_ready, shm_req, pin21, pin23, pin68, lamp, mute;
   logic [7:0] rx_data, tx_data, ps_data, resp_data, shm_addr, fab_m;
   logic [1:0] shm_size;
   logic [3:0] delay;
   logic [5:0] ana;
   logic [6:0] fab;
   logic [47:0] regs;
   logic [31:0] gin, gout, gpio_m, seed = 32'hd9de;
   logic [7:0] bad [6] = '{8'h00, 8'h11, 8'h58, 8'h8b, 8'hc4, 8'hff};
   logic [7:0] fo [8] = '{8'h16, 8'h17, 8'h18, 8'h19, 8'h20, 8'h22, 8'h24, 8'h68};
   logic [7:0] fi [8] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h07, 8'h21, 8'h23};
   int err_count = 0;
   int samples_checked = 0;
   always #10 i_clk = ~i_clk;
   host_command_error_checker #(.TICK_CYCLES(4), .TIMEOUT_TICKS(3)) dut_u (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
      .o_rx_ready(rx_ready), .o_tx_valid(tx_valid), .o_tx_data(tx_data),
      .i_tx_ready(tx_ready), .o_ps_valid(ps_valid), .o_ps_data(ps_data),
      .i_ps_ready(ps_ready), .i_ps_resp_valid(resp_valid), .i_ps_resp_data(resp_data),
      .o_ps_resp_ready(resp_ready), .i_shm_req(shm_req), .i_shm_size(shm_size),
      .i_shm_addr(shm_addr), .i_status_regs(regs), .i_analog_in(ana),
      .i_fabric_input_pin_21(pin21), .i_fabric_input_pin_23(pin23), .o_fab_out(fab),
      .o_fabric_output_pin_68(pin68), .i_gpio_in(gin), .o_gpio_out(gout),
      .o_status_lamp_gpio(lamp));
   ps_responder ps_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_valid(ps_valid),
      .i_data(ps_data), .o_ready(ps_ready), .o_resp_valid(resp_valid),
      .o_resp_data(resp_data), .i_resp_ready(resp_ready), .i_mute(mute), .i_delay(delay));
   ////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic final_report();
      if (err_count == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // ready is sampled at the falling edge so the next rising edge surely takes the byte
   task automatic send(input logic [7:0] b);
      int n;
      @(negedge i_clk);
      rx_valid = 1'b1;
      rx_data = b;
      for (n = 0; n < 100 && !rx_ready; n++) @(negedge i_clk);
      chk("rx ready", 1, rx_ready);
      @(posedge i_clk);
   endtask
   task automatic reply(input logic [7:0] exp);
      int n;
      @(negedge i_clk);
      rx_valid = 1'b0;
      for (n = 0; n < 200 && !tx_valid; n++) @(negedge i_clk);
      // random stall on the reply side, the byte must stand meanwhile
      repeat (rnd() % 3) @(negedge i_clk);
      chk("reply", {1'b1, exp}, {tx_valid, tx_data});
      tx_ready = 1'b1;
      @(negedge i_clk);
      tx_ready = 1'b0;
   endtask
   task automatic cmd(input logic [7:0] op, input logic [7:0] prm, input bit two,
      input logic [7:0] exp);
      send(op);
      if (two) send(prm);
      reply(exp);
   endtask
   task automatic shm(input logic [1:0] sz, input logic [7:0] a);
      @(negedge i_clk);
      shm_req = 1'b1;
      shm_size = sz;
      shm_addr = a;
      @(negedge i_clk);
      shm_req = 1'b0;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      #400000;
      err_count++;
      final_report();
   end
   initial begin
      int i, b, c;
      logic [7:0] code;
      i_rst_n = 1'b0;
      {rx_valid, rx_data, tx_ready, shm_req, shm_size, shm_addr, mute, delay} = '0;
      regs[47:16] = rnd();
      regs[15:0] = 16'(rnd());
      ana = 6'(rnd());
      {pin21, pin23} = 2'(rnd());
      gin = rnd();
      fab_m = 8'h00;
      gpio_m = 32'hffff_ffff;
      repeat (3) @(posedge i_clk);
      @(negedge i_clk);
      i_rst_n = 1'b1;
      chk("gpio reset", gpio_m, gout);
      chk("lamp reset", 1, lamp);
      for (i = 0; i < 8; i++) cmd(8'h10, 8'(i), 1'b1, i <= 5 ? regs[8*i +: 8] : 8'he0);
      foreach (bad[i]) cmd(bad[i], 8'h00, 1'b0, 8'he1);
      foreach (fo[i]) begin
         cmd(8'h41, fo[i], 1'b1, fo[i]);
         fab_m[i] = 1'b1;
      end
      chk("fabric out", fab_m, {pin68, fab});
      for (i = 0; i < 8; i += 2) begin
         cmd(8'h40, fo[i], 1'b1, fo[i]);
         fab_m[i] = 1'b0;
      end
      cmd(8'h41, 8'h21, 1'b1, 8'he3);
      cmd(8'h40, 8'h04, 1'b1, 8'he2);
      chk("fabric out", fab_m, {pin68, fab});
      foreach (fi[i]) cmd(8'h30, fi[i], 1'b1, i < 6 ? ana[i] : (i == 6 ? pin21 : pin23));
      cmd(8'h30, 8'h04, 1'b1, 8'he4);
      cmd(8'h30, 8'h16, 1'b1, 8'he4);
      for (b = 16; b < 32; b++) begin
         code = 8'(((b / 10) << 4) | (b % 10));
         cmd(8'h90, code, 1'b1, 8'(gin[b]));
         c = int'(rnd() % 2);
         cmd(c ? 8'ha1 : 8'ha0, code, 1'b1, code);
         gpio_m[b] = c[0];
      end
      chk("gpio drive", gpio_m, gout);
      cmd(8'ha0, 8'h24, 1'b1, 8'h24);
      chk("lamp", 0, lamp);
      cmd(8'h90, 8'h15, 1'b1, 8'he4);
      cmd(8'ha0, 8'h1a, 1'b1, 8'he2);
      cmd(8'ha1, 8'h32, 1'b1, 8'he3);
      cmd(8'h70, 8'h00, 1'b0, 8'hc3);
      delay = 4'd6;
      cmd(8'h70, 8'h00, 1'b0, 8'hc3);
      cmd(8'hb0, 8'h00, 1'b0, 8'he9);
      cmd(8'h20, 8'h5a, 1'b1, 8'he9);
      cmd(8'hd0, 8'h00, 1'b0, 8'he9);
      mute = 1'b1;
      cmd(8'h70, 8'h00, 1'b0, 8'he8);
      mute = 1'b0;
      shm(2'h0, 8'h08);
      reply(8'he5);
      shm(2'h1, 8'h03);
      reply(8'he6);
      shm(2'h2, 8'h02);
      reply(8'he7);
      shm(2'h1, 8'h06);
      repeat (4) @(negedge i_clk);
      chk("idle tx", 0, tx_valid);
      final_report();
   end
endmodule // host_command_error_checker_tb
`default_nettype wire
